// ### core/dwo_map.svh
// Purpose: address map, window and count constants for the dma write-ordering pair
// Assumes: 32-bit byte addresses, one clock mclk_i
// Notes: included by the package and by every file except the interface and the group tracker
`ifndef DWO_MAP_SVH
`define DWO_MAP_SVH
`define DWO_SHR_LO 32'h8000_0000
`define DWO_SHR_HI 32'h8001_FFFF
`define DWO_ASY_LO 32'h4000_0000
`define DWO_ASY_HI 32'h67FF_FFFF
`define DWO_DRM_LO 32'hC000_0000
`define DWO_DRM_HI 32'hCFFF_FFFF
`define DWO_L1D_BASE 32'h00F0_0000
`define DWO_L1P_BASE 32'h00E0_0000
`define DWO_L2_BASE 32'h0080_0000
`define DWO_LOC_MASK 32'hFFFF_FFC0
`define DWO_MEM_DEPTH 48
`define DWO_WIN_LSB 11
`define DWO_OUTST_MAX 3'h4
`define DWO_GRP_NUM 9
`endif

// ### core/dwo_pkg.sv
// Purpose: shared types and address decode for both ends
// Assumes: dwo_map.svh constants
// Notes: group codes a..i are 0..8
package dwo_pkg;
`include "dwo_map.svh"
  typedef logic [3:0] dwo_grp_t;
  typedef enum logic [2:0] {K_ALLOC = 3'h0, K_VICT_L1 = 3'h1, K_VICT_L2 = 3'h2,
    K_UNC_LD = 3'h3, K_UNC_ST = 3'h4} dwo_kind_t;
  typedef enum logic [1:0] {DST_L1D = 2'h0, DST_L1P = 2'h1, DST_L2 = 2'h2,
    DST_EXT = 2'h3} dwo_dest_t;
  typedef enum logic [3:0] {S_XA_RD = 4'h0, S_XA_WR = 4'h1, S_XB_RD = 4'h2,
    S_XB_WR = 4'h3, S_XC_RD = 4'h4, S_XC_WR = 4'h5, S_HOST = 4'h6, S_USB0 = 4'h7,
    S_USB1 = 4'h8, S_ETH = 4'h9, S_PRU = 4'hA, S_SATA = 4'hB, S_PAR = 4'hC,
    S_VID = 4'hD} dwo_src_t;
  typedef enum logic [1:0] {SL_IDLE = 2'b01, SL_WAIT = 2'b10} dwo_sl_st_t;
  typedef enum logic [3:0] {E_IDLE = 4'b0001, E_MPACC = 4'b0010, E_SLOT = 4'b0100,
    E_MP = 4'b1000} dwo_ext_st_t;

  // source to group; host, usb and ethernet share one group
  function automatic dwo_grp_t src_grp(input dwo_src_t s);
    case (s)
      S_XA_RD: return 4'h0;
      S_XA_WR: return 4'h1;
      S_XB_RD: return 4'h2;
      S_XB_WR: return 4'h3;
      S_XC_RD: return 4'h4;
      S_XC_WR: return 4'h5;
      S_HOST, S_USB0, S_USB1, S_ETH: return 4'h6;
      S_PRU: return 4'h7;
      default: return 4'h8;
    endcase
  endfunction : src_grp

  // which core memory, or outside, an address hits
  function automatic dwo_dest_t local_dest(input logic [31:0] a);
    if ((a & `DWO_LOC_MASK) == `DWO_L1D_BASE) return DST_L1D;
    if ((a & `DWO_LOC_MASK) == `DWO_L1P_BASE) return DST_L1P;
    if ((a & `DWO_LOC_MASK) == `DWO_L2_BASE) return DST_L2;
    return DST_EXT;
  endfunction : local_dest

  // cacheable external regions
  function automatic logic cacheable(input logic [31:0] a);
    return (a >= `DWO_SHR_LO && a <= `DWO_SHR_HI) ||
      (a >= `DWO_ASY_LO && a <= `DWO_ASY_HI) || (a >= `DWO_DRM_LO && a <= `DWO_DRM_HI);
  endfunction : cacheable
endpackage : dwo_pkg

// ### core/dwo_if.sv
// Purpose: link between the core end and the switch fabric end
// Assumes: one clock, every signal driven by a flip-flop of its owner
// Notes: req/rsp is the slave path, mp is the master-port path
`timescale 1ns/1ps
interface dwo_if (
  input wire logic mclk_i,
  input wire logic reset_i
);
  import dwo_pkg::*;
  logic req_valid;
  logic req_ready;
  logic req_write;
  logic [31:0] req_addr;
  logic [31:0] req_data;
  logic rsp_valid;
  logic rsp_err;
  logic [31:0] rsp_data;
  logic mp_valid;
  logic mp_ready;
  logic mp_write;
  logic [31:0] mp_addr;
  logic [31:0] mp_data;
  logic mp_done;
  logic [31:0] mp_rdata;
  modport core_end (input req_valid, req_write, req_addr, req_data, mp_ready, mp_done,
    mp_rdata, output req_ready, rsp_valid, rsp_err, rsp_data, mp_valid, mp_write,
    mp_addr, mp_data);
  modport fabric_end (output req_valid, req_write, req_addr, req_data, mp_ready, mp_done,
    mp_rdata, input req_ready, rsp_valid, rsp_err, rsp_data, mp_valid, mp_write,
    mp_addr, mp_data);
endinterface : dwo_if

// ### core/dwo_grp_track.sv
// Purpose: per-group pending write bookkeeping in the fabric
// Assumes: issue and retire are single-cycle strobes
// Notes: block_o is combinational, read only inside the fabric
`timescale 1ns/1ps
module dwo_grp_track
  import dwo_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // bookkeeping strobes
  input wire logic issue_i,
  input wire logic issue_ext_i,
  input wire logic [31:0] issue_addr_i,
  input wire logic retire_i,
  input wire logic retire_ext_i,
  // query for the request at the door
  input wire logic q_write_i,
  input wire logic q_ext_i,
  input wire logic [31:0] q_addr_i,
  output logic block_o
);
  logic [3:0] cnt_core;
  logic [3:0] cnt_ext;
  logic [31-`DWO_WIN_LSB:0] win;
  logic ic;
  logic ie;
  logic rc;
  logic re;

  assign ic = issue_i && !issue_ext_i;
  assign ie = issue_i && issue_ext_i;
  assign rc = retire_i && !retire_ext_i;
  assign re = retire_i && retire_ext_i;

  // counts of writes handed in but not yet delivered
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_core <= 4'h0;
      cnt_ext <= 4'h0;
      win <= '0;
    end else begin
      cnt_core <= cnt_core + {3'h0, ic} - {3'h0, rc};
      cnt_ext <= cnt_ext + {3'h0, ie} - {3'h0, re};
      if (ie) begin
        win <= issue_addr_i[31:`DWO_WIN_LSB];
      end
    end
  end

  // writes switch only when the other space is drained; reads wait same space, external ones only in the last external write's window
  always_comb begin
    if (q_write_i) begin
      block_o = q_ext_i ? (cnt_core != 4'h0) : (cnt_ext != 4'h0);
    end else if (q_ext_i) begin
      block_o = (cnt_ext != 4'h0) && (win == q_addr_i[31:`DWO_WIN_LSB]);
    end else begin
      block_o = (cnt_core != 4'h0);
    end
  end
endmodule : dwo_grp_track

// ### core/dwo_core_end.sv
// Purpose: core side: slave port into level1/level2 ram and the master port out
// Assumes: fabric keeps group ordering; cache controller holds requests stable
// Notes: level2 slave writes wait out any core write-back on the master port
`timescale 1ns/1ps
`include "dwo_map.svh"
module dwo_core_end
  import dwo_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // link toward the switch fabric
  dwo_if.core_end lnk,
  // cache controller requests
  input wire logic cache_valid_i,
  input wire dwo_kind_t cache_kind_i,
  input wire logic [31:0] cache_addr_i,
  input wire logic [31:0] cache_data_i,
  input wire logic l2_all_cache_i,
  // cache controller answers and status
  output logic cache_ready_o,
  output logic cache_rsp_valid_o,
  output logic [31:0] cache_rdata_o,
  output logic cache_err_o,
  output logic slave_stall_o
);
  dwo_sl_st_t st;
  dwo_sl_st_t next_st;
  logic [31:0] mem [`DWO_MEM_DEPTH];
  logic slot_write;
  logic [31:0] slot_addr;
  logic [31:0] slot_data;
  logic [2:0] ost;
  logic [2:0] next_ost;
  logic next_mp_valid;
  dwo_dest_t in_dest;
  logic take;
  logic wb_busy;
  logic in_bad;
  logic do_acc;
  logic do_write;
  logic do_err;
  logic [31:0] do_addr;
  logic [31:0] do_data;
  logic [5:0] do_idx;
  dwo_dest_t c_dest;
  logic c_take;
  logic c_local;
  logic c_mp;
  logic c_bad;
  logic [5:0] c_idx;

  // slave path decode and level2 hold decision
  always_comb begin
    in_dest = local_dest(lnk.req_addr);
    take = lnk.req_valid && lnk.req_ready;
    wb_busy = lnk.mp_valid && lnk.mp_write;
    in_bad = (in_dest == DST_EXT) || (in_dest == DST_L2 && l2_all_cache_i);
    next_st = st;
    do_acc = 1'b0;
    do_write = 1'b0;
    do_err = 1'b0;
    do_addr = 32'h0000_0000;
    do_data = 32'h0000_0000;
    case (st)
      SL_IDLE: begin
        if (take) begin
          if (in_bad) begin
            do_err = 1'b1;
          end else if (in_dest == DST_L2 && wb_busy) begin
            next_st = SL_WAIT;
          end else begin
            // level1 never waits here; only the level2 hold stalls it
            do_acc = 1'b1;
            do_write = lnk.req_write;
            do_addr = lnk.req_addr;
            do_data = lnk.req_data;
          end
        end
      end
      SL_WAIT: begin
        // held until the write-back leaves; the write is never dropped
        if (!wb_busy) begin
          next_st = SL_IDLE;
          do_acc = 1'b1;
          do_write = slot_write;
          do_addr = slot_addr;
          do_data = slot_data;
        end
      end
      default: next_st = SL_IDLE;
    endcase
    do_idx = {local_dest(do_addr), do_addr[5:2]};
  end

  // slave state, held request and ready
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st <= SL_IDLE;
      slot_write <= 1'b0;
      slot_addr <= 32'h0000_0000;
      slot_data <= 32'h0000_0000;
      lnk.req_ready <= 1'b0;
      slave_stall_o <= 1'b0;
    end else begin
      st <= next_st;
      lnk.req_ready <= (next_st == SL_IDLE);
      slave_stall_o <= (next_st == SL_WAIT);
      if (st == SL_IDLE && next_st == SL_WAIT) begin
        slot_write <= lnk.req_write;
        slot_addr <= lnk.req_addr;
        slot_data <= lnk.req_data;
      end
    end
  end

  // slave answers: one per accepted request, read data or error
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      lnk.rsp_valid <= 1'b0;
      lnk.rsp_err <= 1'b0;
      lnk.rsp_data <= 32'h0000_0000;
    end else begin
      lnk.rsp_valid <= do_acc || do_err;
      lnk.rsp_err <= do_err;
      lnk.rsp_data <= (do_acc && !do_write) ? mem[do_idx] : 32'h0000_0000;
    end
  end

  // cache request classification
  always_comb begin
    c_take = cache_valid_i && cache_ready_o;
    c_dest = local_dest(cache_addr_i);
    c_idx = {c_dest, cache_addr_i[5:2]};
    c_local = 1'b0;
    c_mp = 1'b0;
    case (cache_kind_i)
      K_VICT_L1: c_local = (c_dest == DST_L2);
      K_ALLOC, K_VICT_L2: c_mp = cacheable(cache_addr_i);
      K_UNC_LD, K_UNC_ST: c_mp = (c_dest == DST_EXT);
      default: c_mp = 1'b0;
    endcase
    c_bad = !c_local && !c_mp;
    next_mp_valid = (lnk.mp_valid && !lnk.mp_ready) || (c_take && c_mp);
    next_ost = ost + {2'h0, lnk.mp_valid && lnk.mp_ready} - {2'h0, lnk.mp_done};
  end

  // ram array: slave writes and level1 victims landing in level2
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      for (int i = 0; i < `DWO_MEM_DEPTH; i++) begin
        mem[i] <= 32'h0000_0000;
      end
    end else begin
      if (do_acc && do_write) begin
        mem[do_idx] <= do_data;
      end
      if (c_take && c_local) begin
        mem[c_idx] <= cache_data_i;
      end
    end
  end

  // master-port command register, held until the fabric takes it
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      lnk.mp_valid <= 1'b0;
      lnk.mp_write <= 1'b0;
      lnk.mp_addr <= 32'h0000_0000;
      lnk.mp_data <= 32'h0000_0000;
    end else begin
      lnk.mp_valid <= next_mp_valid;
      if (c_take && c_mp) begin
        lnk.mp_write <= (cache_kind_i == K_VICT_L2) || (cache_kind_i == K_UNC_ST);
        lnk.mp_addr <= cache_addr_i;
        lnk.mp_data <= cache_data_i;
      end
    end
  end

  // outstanding count lets several commands overlap without overrun
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ost <= 3'h0;
      cache_ready_o <= 1'b0;
    end else begin
      ost <= next_ost;
      cache_ready_o <= !next_mp_valid && (next_ost < `DWO_OUTST_MAX);
    end
  end

  // cache answers
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cache_rsp_valid_o <= 1'b0;
      cache_rdata_o <= 32'h0000_0000;
      cache_err_o <= 1'b0;
    end else begin
      cache_rsp_valid_o <= lnk.mp_done;
      cache_rdata_o <= lnk.mp_rdata;
      cache_err_o <= c_take && c_bad;
    end
  end
endmodule : dwo_core_end

// ### core/dwo_fabric_end.sv
// Purpose: switch fabric end: dma masters in, core slave port and external path out
// Assumes: external side answers each command with one ext_done_i pulse
// Notes: one slot and one external command in flight keep ordering simple
`timescale 1ns/1ps
`include "dwo_map.svh"
module dwo_fabric_end
  import dwo_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // link toward the core
  dwo_if.fabric_end lnk,
  // dma master requests
  input wire logic dreq_valid_i,
  input wire dwo_src_t dreq_src_i,
  input wire logic dreq_write_i,
  input wire logic [31:0] dreq_addr_i,
  input wire logic [31:0] dreq_data_i,
  output logic dreq_ready_o,
  output logic order_block_o,
  // dma master answers
  output logic drsp_valid_o,
  output logic drsp_err_o,
  output logic [31:0] drsp_data_o,
  output dwo_grp_t drsp_grp_o,
  // external memory path
  output logic ext_valid_o,
  output logic ext_write_o,
  output logic [31:0] ext_addr_o,
  output logic [31:0] ext_data_o,
  input wire logic ext_ready_i,
  input wire logic ext_done_i,
  input wire logic [31:0] ext_rdata_i
);
  dwo_ext_st_t es;
  logic slot_ext;
  logic slot_write;
  logic [31:0] slot_addr;
  logic [31:0] slot_data;
  dwo_grp_t slot_grp;
  dwo_grp_t core_grp;
  dwo_grp_t in_grp;
  logic in_ext;
  logic [`DWO_GRP_NUM-1:0] blkv;
  logic blk;
  logic take;
  logic core_acc;
  logic ext_fin;
  logic next_full;
  logic core_wr;

  // group lookup and ordering check at the door
  always_comb begin
    in_grp = src_grp(dreq_src_i);
    in_ext = (local_dest(dreq_addr_i) == DST_EXT);
    blk = blkv[in_grp];
    take = dreq_valid_i && dreq_ready_o && !blk;
    core_acc = lnk.req_valid && lnk.req_ready;
    ext_fin = (es == E_SLOT) && ext_done_i;
    next_full = (lnk.req_valid && !core_acc) || (slot_ext && !ext_fin) || take;
  end

  // one tracker per master group
  for (genvar g = 0; g < `DWO_GRP_NUM; g++) begin : gen_trk
    dwo_grp_track u_trk (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .issue_i(take && dreq_write_i && in_grp == 4'(g)),
      .issue_ext_i(in_ext),
      .issue_addr_i(dreq_addr_i),
      // a parked level2 write stays pending until the core answers it
      .retire_i((lnk.rsp_valid && core_wr && core_grp == 4'(g)) ||
        (ext_fin && slot_write && slot_grp == 4'(g))),
      .retire_ext_i(ext_fin && slot_grp == 4'(g)),
      .q_write_i(dreq_write_i),
      .q_ext_i(in_ext),
      .q_addr_i(dreq_addr_i),
      .block_o(blkv[g])
    );
  end

  // single slot: every dma write is routed from here
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      lnk.req_valid <= 1'b0;
      slot_ext <= 1'b0;
      slot_write <= 1'b0;
      slot_addr <= 32'h0000_0000;
      slot_data <= 32'h0000_0000;
      slot_grp <= 4'h0;
      core_grp <= 4'h0;
      core_wr <= 1'b0;
      dreq_ready_o <= 1'b0;
      order_block_o <= 1'b0;
    end else begin
      dreq_ready_o <= !next_full;
      order_block_o <= dreq_valid_i && dreq_ready_o && blk && dreq_write_i;
      if (core_acc) begin
        lnk.req_valid <= 1'b0;
        core_grp <= slot_grp;
        core_wr <= slot_write;
      end
      if (ext_fin) begin
        slot_ext <= 1'b0;
      end
      if (take) begin
        lnk.req_valid <= !in_ext;
        slot_ext <= in_ext;
        slot_write <= dreq_write_i;
        slot_addr <= dreq_addr_i;
        slot_data <= dreq_data_i;
        slot_grp <= in_grp;
      end
    end
  end
  assign lnk.req_write = slot_write;
  assign lnk.req_addr = slot_addr;
  assign lnk.req_data = slot_data;

  // external path: a waiting slot command goes ahead of a core write-back
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      es <= E_IDLE;
      ext_valid_o <= 1'b0;
      ext_write_o <= 1'b0;
      ext_addr_o <= 32'h0000_0000;
      ext_data_o <= 32'h0000_0000;
      lnk.mp_ready <= 1'b0;
      lnk.mp_done <= 1'b0;
      lnk.mp_rdata <= 32'h0000_0000;
    end else begin
      lnk.mp_done <= 1'b0;
      if (ext_valid_o && ext_ready_i) begin
        ext_valid_o <= 1'b0;
      end
      case (es)
        E_IDLE: begin
          if (slot_ext) begin
            es <= E_SLOT;
            ext_valid_o <= 1'b1;
            ext_write_o <= slot_write;
            ext_addr_o <= slot_addr;
            ext_data_o <= slot_data;
          end else if (lnk.mp_valid) begin
            es <= E_MPACC;
            lnk.mp_ready <= 1'b1;
          end
        end
        E_MPACC: begin
          es <= E_MP;
          lnk.mp_ready <= 1'b0;
          ext_valid_o <= 1'b1;
          ext_write_o <= lnk.mp_write;
          ext_addr_o <= lnk.mp_addr;
          ext_data_o <= lnk.mp_data;
        end
        E_SLOT: begin
          if (ext_done_i) begin
            es <= E_IDLE;
          end
        end
        E_MP: begin
          if (ext_done_i) begin
            es <= E_IDLE;
            lnk.mp_done <= 1'b1;
            lnk.mp_rdata <= ext_rdata_i;
          end
        end
        default: es <= E_IDLE;
      endcase
    end
  end

  // answers to dma masters from the core or the external side
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      drsp_valid_o <= 1'b0;
      drsp_err_o <= 1'b0;
      drsp_data_o <= 32'h0000_0000;
      drsp_grp_o <= 4'h0;
    end else begin
      drsp_valid_o <= lnk.rsp_valid || ext_fin;
      drsp_err_o <= lnk.rsp_valid && lnk.rsp_err;
      drsp_data_o <= lnk.rsp_valid ? lnk.rsp_data : ext_rdata_i;
      drsp_grp_o <= lnk.rsp_valid ? core_grp : slot_grp;
    end
  end
endmodule : dwo_fabric_end

// ### sim/dwo_monitor.sv
// Purpose: link checks between core end and fabric end
// Assumes: one clock, synchronous active-high reset
// Notes: sees only link signals, local decode
`timescale 1ns/1ps
`include "dwo_map.svh"
module dwo_monitor (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // link signals
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [31:0] req_addr,
  input wire logic rsp_valid,
  input wire logic mp_valid,
  input wire logic mp_ready,
  input wire logic mp_write,
  input wire logic [31:0] mp_addr
);
  // decode kept here so the checker does not lean on the package
  logic hit_l2;
  assign hit_l2 = (req_addr & `DWO_LOC_MASK) == `DWO_L2_BASE;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_req_held: assert property (
    req_valid && !req_ready |=> req_valid && $stable(req_addr))
    else $error("waiting request moved");
  a_l1_no_stall: assert property (
    req_valid && req_ready && !hit_l2 |=> rsp_valid)
    else $error("level1 access stalled");
  a_l2_wait_wb: assert property (
    req_valid && req_ready && hit_l2 && mp_valid && mp_write |=> !req_ready && !rsp_valid)
    else $error("level2 write not held behind write-back");
  a_stall_cause: assert property (
    $fell(req_ready) |-> $past(mp_valid && mp_write))
    else $error("stall without write-back");
  a_stall_bound: assert property (
    $fell(req_ready) |-> ##[1:200] rsp_valid)
    else $error("stalled write never answered");
  a_mp_held: assert property (
    mp_valid && !mp_ready |=> mp_valid && $stable(mp_addr))
    else $error("master request moved");
  a_mp_ready_ok: assert property (
    mp_ready |-> mp_valid ##1 !mp_ready)
    else $error("bad master-port grant");
  a_rsp_cause: assert property (
    rsp_valid |-> $past(req_valid && req_ready) || $past(!req_ready))
    else $error("response without request");
endmodule : dwo_monitor

// ### sim/tb_dsp_dma_port_write_ordering.sv
// Purpose: drive both ends, compare against a memory model
// Assumes: ext side answers one command at a time
// Notes: ext responder can hold its done pulse to stall
`timescale 1ns/1ps
`include "dwo_map.svh"
module tb_dsp_dma_port_write_ordering
  import dwo_pkg::*;
;
  logic mclk_i = 0, reset_i = 1, cache_valid_i = 0, l2_all_cache_i = 0;
  logic dreq_valid_i = 0, dreq_write_i = 0, ext_ready_i = 0, ext_done_i = 0;
  logic hold = 0, pend = 0, ew, e;
  dwo_kind_t cache_kind_i = K_ALLOC;
  dwo_src_t dreq_src_i = S_XA_RD;
  logic [31:0] cache_addr_i = 0, cache_data_i = 0, dreq_addr_i = 0, dreq_data_i = 0;
  logic [31:0] ext_rdata_i = 0, ea, ed, a, d, q;
  logic cache_ready_o, cache_rsp_valid_o, cache_err_o, slave_stall_o, dreq_ready_o;
  logic order_block_o, drsp_valid_o, drsp_err_o, ext_valid_o, ext_write_o;
  logic [31:0] cache_rdata_o, drsp_data_o, ext_addr_o, ext_data_o;
  dwo_grp_t drsp_grp_o, g;
  logic [31:0] mdl [logic [31:0]];
  logic [31:0] emem [logic [31:0]];
  logic [31:0] bs [3] = '{`DWO_L1D_BASE, `DWO_L1P_BASE, `DWO_L2_BASE};
  logic [31:0] ca [11] = '{32'h8000_0000, 32'h8001_FFFC, 32'h4000_0000, 32'h67FF_FFFC,
    32'hC000_0000, 32'hCFFF_FFFC, 32'h2000_0000, 32'h6800_0000, 32'hD000_0000,
    32'h7FFF_FFFC, `DWO_L1D_BASE};
  int err_total = 0, check_count = 0, nrsp = 0, nerr = 0, nblk = 0, r0, e0, b0;

  always #20 mclk_i = ~mclk_i;
  dwo_if i_dwo_if (.mclk_i(mclk_i), .reset_i(reset_i));
  dwo_core_end i_dwo_core_end (.mclk_i(mclk_i), .reset_i(reset_i), .lnk(i_dwo_if.core_end),
    .cache_valid_i(cache_valid_i), .cache_kind_i(cache_kind_i), .cache_addr_i(cache_addr_i),
    .cache_data_i(cache_data_i), .l2_all_cache_i(l2_all_cache_i),
    .cache_ready_o(cache_ready_o), .cache_rsp_valid_o(cache_rsp_valid_o),
    .cache_rdata_o(cache_rdata_o), .cache_err_o(cache_err_o), .slave_stall_o(slave_stall_o));
  dwo_fabric_end i_dwo_fabric_end (.mclk_i(mclk_i), .reset_i(reset_i),
    .lnk(i_dwo_if.fabric_end), .dreq_valid_i(dreq_valid_i), .dreq_src_i(dreq_src_i),
    .dreq_write_i(dreq_write_i), .dreq_addr_i(dreq_addr_i), .dreq_data_i(dreq_data_i),
    .dreq_ready_o(dreq_ready_o), .order_block_o(order_block_o), .drsp_valid_o(drsp_valid_o),
    .drsp_err_o(drsp_err_o), .drsp_data_o(drsp_data_o), .drsp_grp_o(drsp_grp_o),
    .ext_valid_o(ext_valid_o), .ext_write_o(ext_write_o), .ext_addr_o(ext_addr_o),
    .ext_data_o(ext_data_o), .ext_ready_i(ext_ready_i), .ext_done_i(ext_done_i),
    .ext_rdata_i(ext_rdata_i));
  dwo_monitor i_dwo_monitor (.mclk_i(mclk_i), .reset_i(reset_i),
    .req_valid(i_dwo_if.req_valid), .req_ready(i_dwo_if.req_ready),
    .req_addr(i_dwo_if.req_addr), .rsp_valid(i_dwo_if.rsp_valid),
    .mp_valid(i_dwo_if.mp_valid), .mp_ready(i_dwo_if.mp_ready),
    .mp_write(i_dwo_if.mp_write), .mp_addr(i_dwo_if.mp_addr));

  // ext responder and pulse tallies; ready is chosen before capture so it holds to the edge
  always @(negedge mclk_i) begin
    if (cache_rsp_valid_o === 1'b1) nrsp++;
    if (cache_err_o === 1'b1) nerr++;
    if (order_block_o === 1'b1) nblk++;
    ext_done_i = 0;
    ext_rdata_i = ~ext_rdata_i; // stale data never lingers
    ext_ready_i = pend ? 1'b0 : 1'($urandom_range(0, 1));
    if (pend && !hold) begin
      ext_done_i = 1;
      ext_rdata_i = emem.exists(ea) ? emem[ea] : 32'h0;
      if (ew) emem[ea] = ed;
      pend = 0;
    end else if (ext_valid_o === 1'b1 && ext_ready_i) begin
      pend = 1;
      ea = ext_addr_o;
      ew = ext_write_o;
      ed = ext_data_o;
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic tmo(input string nm);
    err_total++;
    $display("BAD %s exp done seen timeout", nm);
    test_done();
  endtask : tmo

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one dma request, held until taken, then wait for its answer
  task automatic dma(input int s, input logic w, input logic [31:0] ad, input logic [31:0] dd);
    int n;
    @(negedge mclk_i);
    dreq_valid_i = 1;
    dreq_src_i = dwo_src_t'(s);
    dreq_write_i = w;
    dreq_addr_i = ad;
    dreq_data_i = dd;
    for (n = 0; dreq_ready_o !== 1'b0; n++) begin
      if (n > 300) tmo("take");
      @(negedge mclk_i);
    end
    dreq_valid_i = 0;
    for (n = 0; drsp_valid_o !== 1'b1; n++) begin
      if (n > 300) tmo("answer");
      @(negedge mclk_i);
    end
    q = drsp_data_o;
    e = drsp_err_o;
    g = drsp_grp_o;
  endtask : dma

  task automatic cop(input dwo_kind_t k, input logic [31:0] ad, input logic [31:0] dd);
    int n;
    @(negedge mclk_i);
    cache_valid_i = 1;
    cache_kind_i = k;
    cache_addr_i = ad;
    cache_data_i = dd;
    for (n = 0; cache_ready_o !== 1'b1; n++) begin
      if (n > 300) tmo("cache");
      @(negedge mclk_i);
    end
    @(negedge mclk_i);
    cache_valid_i = 0;
  endtask : cop

  // main sequence
  initial begin
    void'($urandom(339));
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    reset_i = 0;
    repeat (2) @(negedge mclk_i);
    // every source writes a core memory and lands in its group
    for (int i = 0; i < 14; i++) begin
      a = bs[i % 3] + 32'(4 * (i / 3));
      d = $urandom;
      dma(i, 1, a, d);
      mdl[a] = d;
      chk("group", 32'(g), (i < 6) ? i : (i < 10) ? 6 : (i == 10) ? 7 : 8);
      chk("werr", 32'(e), 0);
    end
    for (int i = 0; i < 14; i++) begin
      a = bs[i % 3] + 32'(4 * (i / 3));
      dma(10, 0, a, 0);
      chk("rdata", q, mdl[a]);
    end
    // level1 victim goes straight into level2 ram
    d = $urandom;
    cop(K_VICT_L1, `DWO_L2_BASE + 32'h3C, d);
    dma(0, 0, `DWO_L2_BASE + 32'h3C, 0);
    chk("victim", q, d);
    // cacheable regions and an uncached store to an external address served, the rest refused
    for (int i = 0; i < 11; i++) begin
      r0 = nrsp;
      e0 = nerr;
      cop((i == 6 || i == 10) ? K_UNC_ST : K_ALLOC, ca[i], 0);
      for (int n = 0; nrsp == r0 && nerr == e0; n++) begin
        if (n > 300) tmo("cache answer");
        @(negedge mclk_i);
      end
      chk("served", 32'(nrsp - r0), 32'(i < 7));
      chk("refused", 32'(nerr - e0), 32'(i >= 7));
    end
    // level2 write parks behind a stuck write-back and is not lost
    // same group's external write must wait for the parked one
    hold = 1;
    r0 = nrsp;
    b0 = nblk;
    cop(K_VICT_L2, 32'hC000_0100, 32'h1);
    cop(K_VICT_L2, 32'hC000_0200, 32'h2);
    d = $urandom;
    fork
      dma(3, 1, `DWO_L2_BASE + 32'h8, d);
      begin
        repeat (8) @(negedge mclk_i);
        chk("stall", 32'(slave_stall_o), 1);
        dma(3, 1, 32'hC000_0800, ~d);
      end
      begin
        repeat (14) @(negedge mclk_i);
        chk("blocked", 32'(nblk != b0), 1);
        hold = 0;
      end
    join
    mdl[`DWO_L2_BASE + 32'h8] = d;
    dma(5, 0, `DWO_L2_BASE + 32'h8, 0);
    chk("kept", q, d);
    dma(6, 0, 32'hC000_0800, 0);
    chk("late ext", q, ~d);
    repeat (20) @(negedge mclk_i);
    chk("wb count", 32'(nrsp - r0), 2);
    // uncached load returns the written-back word
    r0 = nrsp;
    cop(K_UNC_LD, 32'hC000_0100, 0);
    for (int n = 0; nrsp == r0; n++) begin
      if (n > 300) tmo("load");
      @(negedge mclk_i);
    end
    chk("load data", cache_rdata_o, 32'h1);
    // one group switches destination after completion; reads see writes
    b0 = nblk;
    d = $urandom;
    dma(9, 1, `DWO_L1D_BASE + 32'h8, d);
    dma(7, 1, 32'hC000_0400, d);
    dma(6, 0, 32'hC000_0400, 0);
    chk("ext read", q, d);
    dma(6, 0, 32'hC000_0104, 0);
    dma(6, 0, 32'hC000_0100, 0);
    chk("wb data", q, 1);
    chk("no block", 32'(nblk - b0), 0);
    // level2 as all cache turns dma away
    l2_all_cache_i = 1;
    dma(12, 1, `DWO_L2_BASE, 32'h5);
    chk("l2 err", 32'(e), 1);
    l2_all_cache_i = 0;
    test_done();
  end
endmodule : tb_dsp_dma_port_write_ordering
